// ### pbd_dialler.v
// Keyboard entry, digit store and replay core of a pulse dialler.
// Assumes keypad inputs synchronous to clock; all levels are logic, 1 = idle except on inhibit and reset.
//
// Contract
// - Code sampled only while strobe low
// - Strobe fall starts 8.5 ms debounce
// - Early strobe release restarts debounce timer
// - Invalid codes dropped; valid digits stored
// - Access pause goes to its own store
// - Mute low on write, high after dialling
// - Access pause releases mute
// - 20 digits, non-destructive readout
// - Four parallel 21-bit digit registers
// - Marker register of 21 stages, one per slot
// - Empty slot holds marker until redial
// - At most 20 digits, one slot empty
// - Mute held 33 ms after last pulse
// - Pulse rate scales with phase clock
// - Logic 1 means idle negative level
// - Dial strobe low while out-pulsing
// - Pre-digit pause equals inter-digit pause
// - Inhibit toggles redial mode outside access pause, output low
`timescale 1ns/100ps
`include "pbd_defs.vh"
module pbd_dialler
#(
  parameter DEB_CYC = (`PBD_DEB_US * (`PBD_PHASE_KHZ) + 999) / 1000,
  parameter MUTE_CYC = (`PBD_MUTE_TAIL_US * (`PBD_PHASE_KHZ) + 999) / 1000,
  parameter PULSE_CYC = `PBD_PULSE_MS * `PBD_PHASE_KHZ,
  parameter IDP_CYC = 8 * `PBD_PULSE_MS * `PBD_PHASE_KHZ,
  parameter PH_DIV = `PBD_CLK_KHZ / `PBD_PHASE_KHZ
)
(
  input wire clock,
  input wire reset,
  input wire [3:0] key_code_inputs,
  input wire key_strobe,
  input wire inhibit,
  output reg mute,
  output reg line_pulse,
  output reg dial_strobe,
  output reg redial_out,
  output reg access_pause_out,
  output reg [4:0] digit_count
);
  localparam N = `PBD_STORE_LEN;
  localparam S_IDLE = 3'd0;
  localparam S_PAUSE = 3'd1;
  localparam S_LOAD = 3'd2;
  localparam S_MARK = 3'd3;
  localparam S_SPACE = 3'd4;
  localparam S_TAIL = 3'd5;
  localparam S_APAUSE = 3'd6;

  // ==========================================
  // Phase enable
  reg [15:0] ph_cnt;
  wire tick = (ph_cnt == PH_DIV[15:0] - 16'h0001);
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      ph_cnt <= 16'h0000;
    else if (tick)
      ph_cnt <= 16'h0000;
    else
      ph_cnt <= ph_cnt + 16'h0001;
  end

  // ==========================================
  // Strobe debounce and code conversion
  reg [15:0] deb_cnt;
  reg deb_done;
  reg strobe_d;
  reg key_valid;
  reg key_pause;
  reg [3:0] key_bcd;
  always @*
  begin
    key_valid = 1'b1;
    key_pause = 1'b0;
    key_bcd = key_code_inputs;
    if (key_code_inputs == `PBD_KEY_PAUSE)
    begin
      key_pause = 1'b1;
      key_valid = 1'b0;
    end
    else if (key_code_inputs == `PBD_KEY_ZERO)
      key_bcd = 4'h0;
    else if (key_code_inputs > 4'h9 && key_code_inputs != 4'hf)
      key_valid = 1'b0;
    else if (key_code_inputs == 4'hf)
      key_bcd = 4'h0;
  end

  wire accept = !key_strobe && !deb_done && tick && (deb_cnt == DEB_CYC[15:0] - 16'h0001);

  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      deb_cnt <= 16'h0000;
      deb_done <= 1'b0;
      strobe_d <= 1'b1;
    end
    else
    begin
      strobe_d <= key_strobe;
      if (key_strobe)
      begin
        deb_cnt <= 16'h0000;
        deb_done <= 1'b0;
      end
      else if (strobe_d)
        deb_cnt <= 16'h0000;
      else if (accept)
        deb_done <= 1'b1;
      else if (tick && !deb_done)
        deb_cnt <= deb_cnt + 16'h0001;
    end
  end

  // ==========================================
  // Digit store: four data rings plus marker ring
  reg [N-1:0] store_bit [0:3];
  reg [N-1:0] occupied;
  reg [N-1:0] pause_slot;
  reg [4:0] wr_ptr;
  reg [4:0] rd_ptr;
  reg [2:0] state;
  reg [15:0] tmr;
  reg [3:0] pulses;
  reg redial_mode;
  reg inhibit_d;
  // Slot twenty is never written: its empty state marks the end of the number
  wire full = (digit_count == `PBD_MAX_DIGITS);
  wire write_digit = accept && key_valid && !full;
  wire write_pause = accept && key_pause && !full;
  wire slot_full = occupied[rd_ptr];
  wire [3:0] rd_digit = {store_bit[3][rd_ptr], store_bit[2][rd_ptr],
    store_bit[1][rd_ptr], store_bit[0][rd_ptr]};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_ring
      always @(posedge clock or posedge reset)
      begin
        if (reset)
          store_bit[g] <= {N{1'b0}};
        else if (write_digit)
          store_bit[g][wr_ptr] <= key_bcd[g];
      end
    end
  endgenerate

  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      occupied <= {N{1'b0}};
      pause_slot <= {N{1'b0}};
      wr_ptr <= 5'd0;
      digit_count <= 5'd0;
    end
    else if (write_digit || write_pause)
    begin
      occupied[wr_ptr] <= 1'b1;
      pause_slot[wr_ptr] <= write_pause;
      wr_ptr <= wr_ptr + 5'd1;
      digit_count <= digit_count + 5'd1;
    end
  end

  // ==========================================
  // Replay sequencer
  wire inh_rise = inhibit && !inhibit_d;
  wire in_apause = (state == S_APAUSE);
  wire [3:0] n_pulses = (rd_digit == 4'h0) ? 4'ha : rd_digit;
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state <= S_IDLE;
      tmr <= 16'h0000;
      pulses <= 4'h0;
      rd_ptr <= 5'd0;
      redial_mode <= 1'b0;
      inhibit_d <= 1'b0;
      mute <= 1'b1;
      line_pulse <= 1'b1;
      dial_strobe <= 1'b1;
      redial_out <= 1'b1;
      access_pause_out <= 1'b1;
    end
    else
    begin
      inhibit_d <= inhibit;
      if (inh_rise && !in_apause)
      begin
        redial_mode <= !redial_mode;
        redial_out <= redial_mode;
        if (redial_mode)
          rd_ptr <= 5'd0;
      end
      if (write_digit || write_pause)
        mute <= 1'b0;
      if (tick)
      begin
        case (state)
          S_IDLE:
          begin
            if (slot_full && !redial_mode)
            begin
              state <= S_PAUSE;
              tmr <= 16'h0000;
            end
          end
          S_PAUSE:
          begin
            if (tmr >= IDP_CYC[15:0] - 16'h0001)
              state <= S_LOAD;
            else
              tmr <= tmr + 16'h0001;
          end
          S_LOAD:
          begin
            tmr <= 16'h0000;
            if (!slot_full)
              state <= S_IDLE;
            else if (pause_slot[rd_ptr])
            begin
              mute <= 1'b1;
              access_pause_out <= 1'b0;
              rd_ptr <= rd_ptr + 5'd1;
              state <= S_APAUSE;
            end
            else
            begin
              pulses <= n_pulses;
              rd_ptr <= rd_ptr + 5'd1;
              mute <= 1'b0;
              dial_strobe <= 1'b0;
              state <= S_MARK;
            end
          end
          S_MARK:
          begin
            line_pulse <= 1'b0;
            if (tmr >= PULSE_CYC[15:0] * 16'd2 / 16'd3)
            begin
              tmr <= 16'h0000;
              line_pulse <= 1'b1;
              pulses <= pulses - 4'h1;
              state <= S_SPACE;
            end
            else
              tmr <= tmr + 16'h0001;
          end
          S_SPACE:
          begin
            if (tmr >= PULSE_CYC[15:0] / 16'd3)
            begin
              tmr <= 16'h0000;
              state <= (pulses == 4'h0) ? S_TAIL : S_MARK;
            end
            else
              tmr <= tmr + 16'h0001;
          end
          S_TAIL:
          begin
            // A digit written this very cycle is not yet marked occupied,
            // so the write keeps the line muted instead of losing the race
            if (tmr >= MUTE_CYC[15:0])
            begin
              dial_strobe <= 1'b1;
              if (!occupied[rd_ptr] && !(write_digit || write_pause))
                mute <= 1'b1;
              tmr <= 16'h0000;
              state <= S_PAUSE;
            end
            else
              tmr <= tmr + 16'h0001;
          end
          S_APAUSE:
          begin
            if (!inhibit)
            begin
              access_pause_out <= 1'b1;
              state <= S_PAUSE;
            end
          end
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// ### pbd_defs.vh
// Constants for the push-button dialler store block.
// Assumes a 50 MHz system clock; included by the dialler module only.
`ifndef PBD_DEFS_VH
`define PBD_DEFS_VH
// ==========================================
// Timing
`define PBD_CLK_KHZ 50000
`define PBD_PHASE_KHZ 18
`define PBD_DEB_US 8500
`define PBD_MUTE_TAIL_US 33000
`define PBD_PULSE_MS 100
// ==========================================
// Store geometry
`define PBD_STORE_LEN 21
`define PBD_MAX_DIGITS 5'h14
// ==========================================
// Key codes
`define PBD_KEY_PAUSE 4'hb
`define PBD_KEY_ZERO 4'ha
`endif

// ### pbd_dialler_checker.sv
// Port assertions for the dialler store block.
// Bound to every pbd_dialler; one clock domain.
`timescale 1ns/100ps
module pbd_dialler_checker
#(
  parameter DEB_CYC = 4,
  parameter PH_DIV = 2
)
(
  input wire clock,
  input wire reset,
  input wire [3:0] key_code_inputs,
  input wire key_strobe,
  input wire inhibit,
  input wire mute,
  input wire line_pulse,
  input wire dial_strobe,
  input wire redial_out,
  input wire access_pause_out,
  input wire [4:0] digit_count
);
  reg [15:0] low_run;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ====
  // Strobe low run, saturating so long holds never wrap
  always @(posedge clock or posedge reset)
    if (reset || key_strobe)
      low_run <= 16'h0;
    else if (low_run != 16'hffff)
      low_run <= low_run + 16'h1;
  // ====
  // Rules
  AST_CNT_MAX: assert property (digit_count <= 5'h14)
    else $error("store count above twenty");
  AST_CNT_STEP: assert property (digit_count != $past(digit_count) |->
    digit_count == $past(digit_count) + 5'h1) else $error("store count jumped");
  AST_DEB_LOW: assert property (digit_count > $past(digit_count) |->
    $past(low_run) >= (DEB_CYC - 1) * PH_DIV) else $error("key taken before debounce");
  AST_CODE_OK: assert property (digit_count > $past(digit_count) |->
    !($past(key_code_inputs) inside {4'hc, 4'hd, 4'he})) else $error("bad code stored");
  AST_WRITE_MUTE: assert property (digit_count > $past(digit_count) &&
    $past(key_code_inputs) != 4'hb |-> !mute) else $error("no mute on write");
  AST_PULSE_STROBE: assert property (!line_pulse |-> !dial_strobe)
    else $error("pulse outside dial strobe");
  AST_PULSE_MUTE: assert property (!line_pulse |-> !mute)
    else $error("pulse while unmuted");
  AST_MUTE_TAIL: assert property ($rose(line_pulse) |-> (!mute && !dial_strobe) [*6])
    else $error("tail after pulse too short");
  AST_REDIAL_CAUSE: assert property ($changed(redial_out) |->
    $past(inhibit) || $past(inhibit, 2) || $past(inhibit, 3)) else $error("redial moved alone");
endmodule
bind pbd_dialler pbd_dialler_checker #(.DEB_CYC(DEB_CYC), .PH_DIV(PH_DIV)) u_chk (
  .clock(clock), .reset(reset), .key_code_inputs(key_code_inputs),
  .key_strobe(key_strobe), .inhibit(inhibit), .mute(mute), .line_pulse(line_pulse),
  .dial_strobe(dial_strobe), .redial_out(redial_out),
  .access_pause_out(access_pause_out), .digit_count(digit_count));

// ### pbd_keypad.sv
// Keypad model: four code lines and a strobe.
// Changes its lines just after a rising clock edge.
`timescale 1ns/100ps
module pbd_keypad
(
  input wire clock,
  output reg [3:0] code,
  output reg strobe
);
  initial
  begin
    code = 4'hf;
    strobe = 1'b1;
  end
  // ====
  // Press
  task press(input [3:0] c, input integer hold);
  begin
    @(posedge clock);
    #1 code = c;
    strobe = 1'b0;
    repeat (hold) @(posedge clock);
    #1 strobe = 1'b1;
    code = 4'hf;
    repeat (2) @(posedge clock);
  end
  endtask
endmodule

// ### pbd_dialler_tb.sv
// Self-checking bench for the dialler store block.
// Uses the keypad model; shortened phase counts.
`timescale 1ns/100ps
module pbd_dialler_tb;
  localparam HOLD = 12;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg inhibit = 1'b0;
  wire [3:0] code;
  wire strobe, mute, line_pulse, dial_strobe, redial_out, ap_out;
  wire [4:0] count;
  integer err_total = 0;
  integer n_tests = 0;
  integer npulse = 0;
  integer nstore = 0;
  integer i;
  always #10 clock = ~clock;
  always @(negedge line_pulse) npulse = npulse + 1;
  pbd_keypad u_kp (.clock(clock), .code(code), .strobe(strobe));
  pbd_dialler #(.PH_DIV(2), .DEB_CYC(4), .MUTE_CYC(4), .PULSE_CYC(6), .IDP_CYC(8)) u_dut (
    .clock(clock), .reset(reset), .key_code_inputs(code), .key_strobe(strobe),
    .inhibit(inhibit), .mute(mute), .line_pulse(line_pulse), .dial_strobe(dial_strobe),
    .redial_out(redial_out), .access_pause_out(ap_out), .digit_count(count));
  // ====
  // Shared tasks
  task chk(input string name, input [7:0] exp, input [7:0] got);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("unexpected %0s: expected %h, seen %h", name, exp, got);
    end
  end
  endtask
  task conclude;
  begin
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task key(input [3:0] c, input integer hold);
  begin
    u_kp.press(c, hold);
    chk("count", nstore, count);
  end
  endtask
  task wait_idle;
    for (i = 0; i < 4000 && mute !== 1'b1; i = i + 1) @(posedge clock);
  endtask
  task toggle;
  begin
    @(posedge clock);
    #1 inhibit = 1'b1;
    repeat (4) @(posedge clock);
    #1 inhibit = 1'b0;
    repeat (2) @(posedge clock);
  end
  endtask
  // ====
  // Scenarios
  task t_dial(input [3:0] c, input integer n);
    integer p;
  begin
    p = npulse;
    nstore = nstore + 1;
    key(c, HOLD);
    chk("mute on write", 0, mute);
    wait_idle;
    chk("pulses", n, npulse - p);
    chk("strobe out", 1, dial_strobe);
    $display("dial test done");
  end
  endtask
  task t_reject;
  begin
    key(4'h5, 4);
    key(4'h5, 4);
    for (i = 12; i < 15; i = i + 1)
      key(i, HOLD);
    chk("mute idle", 1, mute);
    $display("reject test done");
  end
  endtask
  task t_redial;
    integer p;
  begin
    p = npulse;
    toggle;
    chk("redial on", 0, redial_out);
    toggle;
    chk("redial off", 1, redial_out);
    for (i = 0; i < 200 && mute !== 1'b0; i = i + 1) @(posedge clock);
    wait_idle;
    chk("replay pulses", 13, npulse - p);
    $display("redial test done");
  end
  endtask
  task t_pause_fill;
  begin
    nstore = nstore + 1;
    key(4'hb, HOLD);
    for (i = 0; i < 2000 && ap_out !== 1'b0; i = i + 1) @(posedge clock);
    chk("pause out", 0, ap_out);
    chk("mute at pause", 1, mute);
    while (nstore < 20)
    begin
      nstore = nstore + 1;
      key(4'h1, HOLD);
    end
    key(4'h1, HOLD);
    $display("pause and fill test done");
  end
  endtask
  // ====
  // Main sequence and watchdog
  initial
  begin
    repeat (6) @(posedge clock);
    #1 reset = 1'b0;
    chk("idle outputs", 8'h1f, {mute, line_pulse, dial_strobe, redial_out, ap_out});
    chk("count", 0, count);
    t_dial(4'h3, 3);
    t_dial(4'ha, 10);
    t_reject;
    t_redial;
    t_dial(4'hf, 10);
    t_pause_fill;
    conclude;
  end
  initial
  begin
    repeat (30000) @(posedge clock);
    err_total = err_total + 1;
    conclude;
  end
endmodule
